// *** core/fppc_map.svh ***
// timing constants and codes for the front panel protection control block
// assumes ref_clk at 100 MHz; included by bare name
`ifndef FPPC_MAP_SVH
`define FPPC_MAP_SVH
`define FPPC_CLK_HZ 100000000
`define FPPC_UNLOCK_HOLD_MS 4000
`define FPPC_UNLOCK_HOLD_CYC ((`FPPC_CLK_HZ / 1000) * `FPPC_UNLOCK_HOLD_MS)
`define FPPC_DISP_TIMEOUT_MS 10000
`define FPPC_DISP_TIMEOUT_CYC ((`FPPC_CLK_HZ / 1000) * `FPPC_DISP_TIMEOUT_MS)
`define FPPC_DEBOUNCE_US 5000
`define FPPC_DEBOUNCE_CYC ((`FPPC_CLK_HZ / 1000000) * `FPPC_DEBOUNCE_US)
`define FPPC_BLINK_MS 250
`define FPPC_BLINK_CYC ((`FPPC_CLK_HZ / 1000) * `FPPC_BLINK_MS)
`define FPPC_RES_FINE 2'h0
`define FPPC_RES_COARSE 2'h2
`define FPPC_FUNC_LAST 6'h0F
`define FPPC_NUM_KEYS 9
`endif

// *** core/fppc_pkg.sv ***
// types shared by the front panel protection control block
// assumes nothing beyond the map header constants
package fppc_pkg;
  // debounced key set; bit order is also the raw key vector order
  typedef struct packed {
    logic resolution_key;
    logic recall;
    logic cancel;
    logic enter;
    logic output_key;
    logic up;
    logic down;
    logic func;
    logic select;
  } fppc_keys_t;
  typedef enum logic [1:0] {
    FPPC_VIEW_MEAS = 2'b00,
    FPPC_VIEW_SET = 2'b01,
    FPPC_VIEW_MENU = 2'b10
  } fppc_view_t;
  typedef struct packed {
    logic ready;
    logic remote;
    logic addressed;
    logic srq;
    logic overvoltage_trip;
    logic otp;
    logic overcurrent_trip;
    logic ocp_armed;
    logic panel_lock;
  } fppc_leds_t;
endpackage

// *** core/fppc_top.sv ***
// front panel and protective shutdown control of a programmable supply
// assumes all inputs synchronous to ref_clk, raw keys active high
// Operation
// - overvoltage sets trip and turns output off
// - after overvoltage, output needs output-on command
// - overheat sets trip and deactivates output
// - recall startup re-enables output after cooling
// - long constant-current with arming trips overcurrent
// - lock lamp ignores bus local lockout
// - function key steps codes forward, up back
// - pending alternative blinks, enter commits
// - knob, select or recall key discards, leaves menu
// - non-blinking params apply; menu remembers entry
// - resolution key cycles three lowest digits
// - per-display step size, reset to fine
// - cancel during adjustment restores default view
// - remote lamp lit, panel ignored except cancel
// - local lockout blocks cancel return to local
// - cancel plus enter triggers default reset
// - cancel plus recall locks panel, lamp on
// - cancel held four seconds releases lock
// - trigger panel-lock setting blocks cancel too
// - ready steady, blinking, or off
// - addressed and service-request lamps follow bus
// - overcurrent-armed lamp follows arming only
// - setting view returns after ten seconds idle
`timescale 1ns/1ps
`include "fppc_map.svh"
module fppc_top #(
  parameter int unsigned HOLD_CYC = `FPPC_UNLOCK_HOLD_CYC,
  parameter int unsigned IDLE_CYC = `FPPC_DISP_TIMEOUT_CYC,
  parameter int unsigned DEB_CYC = `FPPC_DEBOUNCE_CYC,
  parameter int unsigned BLINK_CYC = `FPPC_BLINK_CYC,
  parameter int unsigned MEAS_W = 16,
  parameter int unsigned DLY_W = 32
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [`FPPC_NUM_KEYS-1:0] keys_raw,
  input wire logic knob_left_turn,
  input wire logic knob_right_turn,
  input wire logic [MEAS_W-1:0] meas_voltage,
  input wire logic [MEAS_W-1:0] overvoltage_threshold,
  input wire logic overheat,
  input wire logic cc_mode,
  input wire logic overcurrent_shutdown_armed,
  input wire logic [DLY_W-1:0] ocp_delay_cyc,
  input wire logic startup_recall,
  input wire logic output_on_cmd,
  input wire logic output_off_cmd,
  input wire logic remote_cmd,
  input wire logic local_lockout,
  input wire logic trigger_in,
  input wire logic trigger_panel_lock_setting,
  input wire logic self_test,
  input wire logic sequence_run,
  input wire logic bus_addressed,
  input wire logic bus_srq,
  input wire logic param_numeric,
  input wire logic param_blinks,
  output logic output_enable,
  output fppc_pkg::fppc_leds_t leds,
  output fppc_pkg::fppc_view_t left_view,
  output fppc_pkg::fppc_view_t right_view,
  output logic [5:0] func_code,
  output logic pend_blink,
  output logic param_commit,
  output logic param_step_up,
  output logic param_step_down,
  output logic [1:0] left_res,
  output logic [1:0] right_res,
  output logic default_reset
);
  // debounce state
  fppc_pkg::fppc_keys_t key_ff, nxt_key, prev_ff, nxt_prev, kp;
  logic [`FPPC_NUM_KEYS-1:0] same_ff, nxt_same;
  logic [31:0] deb_cnt_ff [`FPPC_NUM_KEYS];
  logic [31:0] nxt_deb_cnt [`FPPC_NUM_KEYS];
  // protection and panel state
  logic out_ff, nxt_out, ovp_ff, nxt_ovp, otp_ff, nxt_otp, ocp_ff, nxt_ocp;
  logic [DLY_W-1:0] cc_cnt_ff, nxt_cc_cnt;
  logic remote_ff, nxt_remote, lock_ff, nxt_lock;
  logic [31:0] hold_ff, nxt_hold, idle_ff, nxt_idle, blink_cnt_ff, nxt_blink_cnt;
  logic blink_ff, nxt_blink;
  fppc_pkg::fppc_view_t lv_ff, nxt_lv, rv_ff, nxt_rv;
  logic [5:0] code_ff, nxt_code;
  logic pend_ff, nxt_pend, commit_ff, nxt_commit, sup_ff, nxt_sup, sdn_ff, nxt_sdn;
  logic [1:0] lres_ff, nxt_lres, rres_ff, nxt_rres;
  logic rst_ff, nxt_rst, res_sel_ff, nxt_res_sel;
  fppc_pkg::fppc_leds_t leds_ff, nxt_leds;
  logic panel_off, cancel_blocked, knob;

  // step a resolution digit cyclically among the three lowest places
  function automatic logic [1:0] res_step(input logic [1:0] r);
    res_step = (r == `FPPC_RES_COARSE) ? `FPPC_RES_FINE : r + 2'h1;
  endfunction

  // a key level is accepted only after it stands still DEB_CYC cycles
  always_comb begin
    nxt_key = key_ff;
    nxt_same = same_ff;
    for (int i = 0; i < `FPPC_NUM_KEYS; i++) begin
      nxt_deb_cnt[i] = deb_cnt_ff[i];
      if (keys_raw[i] == key_ff[i]) begin
        nxt_deb_cnt[i] = 32'h0;
      end else if (deb_cnt_ff[i] >= DEB_CYC - 1) begin
        nxt_key[i] = keys_raw[i];
        nxt_deb_cnt[i] = 32'h0;
      end else begin
        nxt_deb_cnt[i] = deb_cnt_ff[i] + 32'h1;
      end
      nxt_same[i] = (keys_raw[i] == key_ff[i]);
    end
    nxt_prev = key_ff;
    kp = key_ff & ~prev_ff; // one-cycle press events
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      key_ff <= '0;
      prev_ff <= '0;
      same_ff <= '0;
      for (int i = 0; i < `FPPC_NUM_KEYS; i++) begin
        deb_cnt_ff[i] <= 32'h0;
      end
    end else begin
      key_ff <= nxt_key;
      prev_ff <= nxt_prev;
      same_ff <= nxt_same;
      for (int i = 0; i < `FPPC_NUM_KEYS; i++) begin
        deb_cnt_ff[i] <= nxt_deb_cnt[i];
      end
    end
  end

  // output enable and the three trips; a new trip wins over output-on
  always_comb begin
    nxt_ovp = ovp_ff;
    nxt_otp = otp_ff;
    nxt_ocp = ocp_ff;
    nxt_out = out_ff;
    nxt_cc_cnt = (out_ff && cc_mode && overcurrent_shutdown_armed) ? cc_cnt_ff + 1'b1 : '0;
    if (output_on_cmd || (kp.output_key && !panel_off && !out_ff)) begin
      nxt_out = 1'b1; // on command or output key re-enables, as does recall after cooling
      nxt_ovp = 1'b0;
      nxt_ocp = 1'b0;
    end
    if (output_off_cmd || (kp.output_key && !panel_off && out_ff)) begin
      nxt_out = 1'b0;
    end
    if (otp_ff && !overheat) begin
      nxt_otp = 1'b0;
      if (startup_recall) begin
        nxt_out = 1'b1;
      end
    end
    if (meas_voltage > overvoltage_threshold) begin
      nxt_ovp = 1'b1;
      nxt_out = 1'b0;
    end
    if (overheat) begin
      nxt_otp = 1'b1;
      nxt_out = 1'b0;
    end
    if (out_ff && overcurrent_shutdown_armed && cc_mode && cc_cnt_ff >= ocp_delay_cyc) begin
      nxt_ocp = 1'b1; // re-enable needs output-on
      nxt_out = 1'b0;
      nxt_cc_cnt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      out_ff <= 1'b0;
      ovp_ff <= 1'b0;
      otp_ff <= 1'b0;
      ocp_ff <= 1'b0;
      cc_cnt_ff <= '0;
    end else begin
      out_ff <= nxt_out;
      ovp_ff <= nxt_ovp;
      otp_ff <= nxt_otp;
      ocp_ff <= nxt_ocp;
      cc_cnt_ff <= nxt_cc_cnt;
    end
  end

  // remote/local, lock chords, menu, resolution and display timeout
  assign knob = knob_left_turn | knob_right_turn;
  assign panel_off = remote_ff | lock_ff;
  assign cancel_blocked = local_lockout | (trigger_panel_lock_setting & trigger_in);
  always_comb begin
    nxt_remote = remote_ff;
    nxt_lock = lock_ff;
    nxt_hold = 32'h0;
    nxt_lv = lv_ff;
    nxt_rv = rv_ff;
    nxt_code = code_ff;
    nxt_pend = pend_ff;
    nxt_commit = 1'b0;
    nxt_sup = 1'b0;
    nxt_sdn = 1'b0;
    nxt_lres = lres_ff;
    nxt_rres = rres_ff;
    nxt_rst = 1'b0;
    nxt_res_sel = res_sel_ff;
    nxt_idle = (lv_ff == fppc_pkg::FPPC_VIEW_MEAS && rv_ff == fppc_pkg::FPPC_VIEW_MEAS)
      ? 32'h0 : idle_ff + 32'h1;
    if (remote_cmd) begin
      nxt_remote = 1'b1;
    end else if (remote_ff && kp.cancel && !cancel_blocked) begin
      nxt_remote = 1'b0; // settings untouched
    end
    if (lock_ff && key_ff.cancel && !cancel_blocked) begin
      nxt_hold = hold_ff + 32'h1;
      if (hold_ff >= HOLD_CYC - 1) begin
        nxt_lock = 1'b0;
      end
    end
    if (trigger_panel_lock_setting && trigger_in) begin
      nxt_lock = 1'b1;
    end
    if (!panel_off) begin
      if (key_ff.cancel && kp.enter) begin
        nxt_rst = 1'b1;
        nxt_lres = `FPPC_RES_FINE;
        nxt_rres = `FPPC_RES_FINE;
      end else if (key_ff.cancel && kp.recall) begin
        nxt_lock = 1'b1;
      end else if (kp.cancel) begin
        nxt_lv = fppc_pkg::FPPC_VIEW_MEAS; // pending change dropped
        nxt_rv = fppc_pkg::FPPC_VIEW_MEAS;
        nxt_pend = 1'b0;
      end else if (lv_ff == fppc_pkg::FPPC_VIEW_MENU) begin
        if (kp.func) begin
          nxt_pend = 1'b0;
          nxt_code = key_ff.up ? ((code_ff == 6'h0) ? `FPPC_FUNC_LAST : code_ff - 6'h1)
            : ((code_ff == `FPPC_FUNC_LAST) ? 6'h0 : code_ff + 6'h1);
        end else if (kp.up || kp.down) begin
          nxt_pend = param_blinks; // non-blinking applies at once
          nxt_sup = kp.up;
          nxt_sdn = kp.down;
        end else if (kp.enter) begin
          nxt_commit = pend_ff;
          nxt_pend = 1'b0;
          nxt_lv = fppc_pkg::FPPC_VIEW_MEAS;
          nxt_rv = fppc_pkg::FPPC_VIEW_MEAS;
        end else if (kp.resolution_key && param_numeric) begin
          nxt_rres = res_step(rres_ff);
          nxt_idle = 32'h0;
        end else if (knob || kp.select || kp.recall) begin
          nxt_pend = 1'b0; // discard and leave
          nxt_lv = fppc_pkg::FPPC_VIEW_MEAS;
          nxt_rv = fppc_pkg::FPPC_VIEW_MEAS;
        end
      end else if (kp.func) begin
        nxt_lv = fppc_pkg::FPPC_VIEW_MENU; // code_ff kept: last entry
        nxt_rv = fppc_pkg::FPPC_VIEW_MENU;
        nxt_idle = 32'h0;
      end else begin
        if (knob_left_turn) begin
          nxt_lv = fppc_pkg::FPPC_VIEW_SET;
          nxt_res_sel = 1'b0;
          nxt_idle = 32'h0;
        end
        if (knob_right_turn) begin
          nxt_rv = fppc_pkg::FPPC_VIEW_SET;
          nxt_res_sel = 1'b1;
          nxt_idle = 32'h0;
        end
        if (kp.resolution_key) begin
          if (res_sel_ff) begin
            nxt_rres = res_step(rres_ff);
          end else begin
            nxt_lres = res_step(lres_ff);
          end
          nxt_idle = 32'h0;
        end
        if (kp.enter) begin
          nxt_lv = fppc_pkg::FPPC_VIEW_MEAS;
          nxt_rv = fppc_pkg::FPPC_VIEW_MEAS;
        end
      end
    end
    if (lv_ff == fppc_pkg::FPPC_VIEW_SET || rv_ff == fppc_pkg::FPPC_VIEW_SET) begin
      if (idle_ff >= IDLE_CYC - 1) begin
        nxt_lv = fppc_pkg::FPPC_VIEW_MEAS;
        nxt_rv = fppc_pkg::FPPC_VIEW_MEAS;
      end
    end
    nxt_blink_cnt = (blink_cnt_ff >= BLINK_CYC - 1) ? 32'h0 : blink_cnt_ff + 32'h1;
    nxt_blink = (blink_cnt_ff >= BLINK_CYC - 1) ? ~blink_ff : blink_ff;
    nxt_leds.ready = (self_test || sequence_run) ? blink_ff : !panel_off;
    nxt_leds.remote = remote_ff;
    nxt_leds.addressed = bus_addressed;
    nxt_leds.srq = bus_srq;
    nxt_leds.overvoltage_trip = ovp_ff;
    nxt_leds.otp = otp_ff;
    nxt_leds.overcurrent_trip = ocp_ff;
    nxt_leds.ocp_armed = overcurrent_shutdown_armed;
    nxt_leds.panel_lock = lock_ff; // bus lockout not shown
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      remote_ff <= 1'b0;
      lock_ff <= 1'b0;
      hold_ff <= 32'h0;
      idle_ff <= 32'h0;
      lv_ff <= fppc_pkg::FPPC_VIEW_MEAS;
      rv_ff <= fppc_pkg::FPPC_VIEW_MEAS;
      code_ff <= 6'h0;
      pend_ff <= 1'b0;
      commit_ff <= 1'b0;
      sup_ff <= 1'b0;
      sdn_ff <= 1'b0;
      lres_ff <= `FPPC_RES_FINE;
      rres_ff <= `FPPC_RES_FINE;
      rst_ff <= 1'b0;
      res_sel_ff <= 1'b0;
      blink_cnt_ff <= 32'h0;
      blink_ff <= 1'b0;
      leds_ff <= '0;
    end else begin
      remote_ff <= nxt_remote;
      lock_ff <= nxt_lock;
      hold_ff <= nxt_hold;
      idle_ff <= nxt_idle;
      lv_ff <= nxt_lv;
      rv_ff <= nxt_rv;
      code_ff <= nxt_code;
      pend_ff <= nxt_pend;
      commit_ff <= nxt_commit;
      sup_ff <= nxt_sup;
      sdn_ff <= nxt_sdn;
      lres_ff <= nxt_lres;
      rres_ff <= nxt_rres;
      rst_ff <= nxt_rst;
      res_sel_ff <= nxt_res_sel;
      blink_cnt_ff <= nxt_blink_cnt;
      blink_ff <= nxt_blink;
      leds_ff <= nxt_leds;
    end
  end

  assign output_enable = out_ff;
  assign leds = leds_ff;
  assign left_view = lv_ff;
  assign right_view = rv_ff;
  assign func_code = code_ff;
  assign pend_blink = pend_ff;
  assign param_commit = commit_ff;
  assign param_step_up = sup_ff;
  assign param_step_down = sdn_ff;
  assign left_res = lres_ff;
  assign right_res = rres_ff;
  assign default_reset = rst_ff;
endmodule

// *** verif/fppc_monitor.sv ***
// checker of trip, lamp and key timing seen at the top ports
// assumes binding into fppc_top; one clock, reset sync active high
`timescale 1ns/1ps
module fppc_monitor #(
  parameter int unsigned HOLD_CYC = 20,
  parameter int unsigned MEAS_W = 16
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [8:0] keys_raw,
  input wire logic [MEAS_W-1:0] meas_voltage,
  input wire logic [MEAS_W-1:0] overvoltage_threshold,
  input wire logic overheat,
  input wire logic overcurrent_shutdown_armed,
  input wire logic bus_addressed,
  input wire logic bus_srq,
  input wire logic output_enable,
  input wire fppc_pkg::fppc_leds_t leds,
  input wire logic [1:0] right_res,
  input wire logic default_reset
);
  logic [31:0] run_ff;
  logic [31:0] nxt_run;
  logic prev_ff;
  logic nxt_prev;
  // length of the latest raw cancel run, kept after release since unlock lags debounce
  always_comb begin
    nxt_prev = keys_raw[6];
    nxt_run = run_ff;
    if (keys_raw[6]) nxt_run = prev_ff ? run_ff + 32'h1 : 32'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      run_ff <= 32'h0;
      prev_ff <= 1'b0;
    end else begin
      run_ff <= nxt_run;
      prev_ff <= nxt_prev;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_ovp_off; (meas_voltage > overvoltage_threshold) |=> !output_enable; endproperty
  a_ovp_off: assert property (p_ovp_off)
    else $error("output on above threshold");
  property p_ovp_led; (meas_voltage > overvoltage_threshold) |-> ##2 leds.overvoltage_trip; endproperty
  a_ovp_led: assert property (p_ovp_led)
    else $error("overvoltage lamp missing");
  property p_otp; overheat |=> !output_enable; endproperty
  a_otp: assert property (p_otp)
    else $error("output on while overheated");
  property p_armed; 1'b1 |=> leds.ocp_armed == $past(overcurrent_shutdown_armed); endproperty
  a_armed: assert property (p_armed)
    else $error("armed lamp wrong");
  property p_bus;
    1'b1 |=> leds.addressed == $past(bus_addressed) && leds.srq == $past(bus_srq);
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus lamps wrong");
  property p_res;
    $changed(right_res) |-> right_res == 2'h0 || right_res == $past(right_res) + 2'h1;
  endproperty
  a_res: assert property (p_res)
    else $error("step digit not cyclic");
  property p_pulse; default_reset |=> !default_reset; endproperty
  a_pulse: assert property (p_pulse)
    else $error("default reset not a pulse");
  property p_unlock; !$past(sys_rst) && $fell(leds.panel_lock) |-> run_ff >= HOLD_CYC; endproperty
  a_unlock: assert property (p_unlock)
    else $error("unlocked before hold time");
endmodule
bind fppc_top fppc_monitor #(.HOLD_CYC(HOLD_CYC), .MEAS_W(MEAS_W)) i_fppc_monitor (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .keys_raw(keys_raw), .meas_voltage(meas_voltage),
  .overvoltage_threshold(overvoltage_threshold), .overheat(overheat),
  .overcurrent_shutdown_armed(overcurrent_shutdown_armed), .bus_addressed(bus_addressed),
  .bus_srq(bus_srq), .output_enable(output_enable), .leds(leds), .right_res(right_res),
  .default_reset(default_reset));

// *** verif/fppc_op.sv ***
// operator model: holds and releases panel keys, steps the knobs
// assumes callers sit just after a rising edge; returns there too
`timescale 1ns/1ps
module fppc_op #(
  parameter int unsigned DEB_CYC = 2
) (
  input wire logic ref_clk,
  output logic [8:0] keys_raw,
  output logic knob_left_turn,
  output logic knob_right_turn
);
  // idle panel at time zero
  initial begin
    keys_raw = 9'h000;
    knob_left_turn = 1'b0;
    knob_right_turn = 1'b0;
  end
  // each change is held past debounce plus the lamp stage
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic hold(input int k);
    keys_raw[k] = 1'b1;
    step(DEB_CYC + 4);
  endtask
  task automatic rel(input int k);
    keys_raw[k] = 1'b0;
    step(DEB_CYC + 4);
  endtask
  task automatic press(input int k);
    hold(k);
    rel(k);
  endtask
  // one encoder step, right knob when r is set
  task automatic turn(input bit r);
    knob_right_turn = r;
    knob_left_turn = !r;
    step(1);
    knob_right_turn = 1'b0;
    knob_left_turn = 1'b0;
    step(3);
  endtask
endmodule

// *** verif/fppc_top_bench.sv ***
// self-checking bench for the panel and protection control block
// assumes shortened hold, idle, debounce and blink counts set below
`timescale 1ns/1ps
module fppc_top_bench;
  localparam int unsigned HOLD = 20;
  localparam int unsigned IDLE = 50;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [8:0] keys_raw;
  logic knob_left_turn, knob_right_turn;
  logic [15:0] meas_voltage = 16'h0100;
  logic [15:0] overvoltage_threshold = 16'h0200;
  logic [31:0] ocp_delay_cyc = 32'h0000000A;
  logic overheat = 0, cc_mode = 0, overcurrent_shutdown_armed = 0, startup_recall = 0;
  logic output_on_cmd = 0, output_off_cmd = 0, remote_cmd = 0, local_lockout = 0;
  logic trigger_in = 0, trigger_panel_lock_setting = 0, self_test = 0, sequence_run = 0;
  logic bus_addressed = 0, bus_srq = 0, param_numeric = 0, param_blinks = 1;
  logic output_enable, pend_blink, param_commit, param_step_up, param_step_down, default_reset;
  fppc_pkg::fppc_leds_t leds;
  fppc_pkg::fppc_view_t left_view, right_view;
  logic [5:0] func_code;
  logic [5:0] c;
  logic [1:0] left_res, right_res;
  logic rst_seen, commit_seen;
  int fails = 0;
  int checks_done = 0;
  int ones;
  always #5 ref_clk = ~ref_clk;
  fppc_top #(.HOLD_CYC(HOLD), .IDLE_CYC(IDLE), .DEB_CYC(2), .BLINK_CYC(4)) i_fppc_top (
    .ref_clk, .sys_rst, .keys_raw, .knob_left_turn, .knob_right_turn, .meas_voltage,
    .overvoltage_threshold, .overheat, .cc_mode, .overcurrent_shutdown_armed, .ocp_delay_cyc,
    .startup_recall, .output_on_cmd, .output_off_cmd, .remote_cmd, .local_lockout, .trigger_in,
    .trigger_panel_lock_setting, .self_test, .sequence_run, .bus_addressed, .bus_srq,
    .param_numeric, .param_blinks, .output_enable, .leds, .left_view, .right_view, .func_code,
    .pend_blink, .param_commit, .param_step_up, .param_step_down, .left_res, .right_res,
    .default_reset);
  fppc_op #(.DEB_CYC(2)) i_fppc_op (.ref_clk, .keys_raw, .knob_left_turn, .knob_right_turn);
  // one-cycle pulses are caught here so key tasks need not watch them
  always @(posedge ref_clk) begin
    if (default_reset === 1'b1) rst_seen <= 1'b1;
    if (param_commit === 1'b1) commit_seen <= 1'b1;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic wt(input int n);
    i_fppc_op.step(n);
  endtask
  task automatic on_pulse;
    output_on_cmd = 1'b1;
    wt(1);
    output_on_cmd = 1'b0;
    wt(2);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // trip at one above threshold only, then off until the on command
  task automatic t_ovp;
    on_pulse();
    meas_voltage = 16'h0200;
    wt(3);
    chk("oe at threshold", 1, output_enable);
    meas_voltage = 16'h0201;
    wt(3);
    chk("oe over", 0, output_enable);
    chk("ovp lamp", 1, leds.overvoltage_trip);
    meas_voltage = 16'h0100;
    wt(4);
    chk("oe held off", 0, output_enable);
    on_pulse();
    chk("oe back", 1, output_enable);
    overvoltage_threshold = 16'h00FF;
    wt(3);
    chk("oe thr low", 0, output_enable);
    overvoltage_threshold = 16'h0200;
    on_pulse();
    output_off_cmd = 1'b1;
    wt(1);
    output_off_cmd = 1'b0;
    wt(2);
    chk("oe off cmd", 0, output_enable);
    on_pulse();
  endtask
  // cooling restores output only with recall at startup
  task automatic t_otp;
    startup_recall = 1'b1;
    overheat = 1'b1;
    wt(3);
    chk("oe hot", 0, output_enable);
    chk("otp lamp", 1, leds.otp);
    overheat = 1'b0;
    wt(3);
    chk("oe recall", 1, output_enable);
    startup_recall = 1'b0;
    overheat = 1'b1;
    wt(2);
    overheat = 1'b0;
    wt(4);
    chk("oe no recall", 0, output_enable);
    on_pulse();
  endtask
  task automatic t_ocp;
    ocp_delay_cyc = 32'h0000000C;
    overcurrent_shutdown_armed = 1'b1;
    wt(2);
    cc_mode = 1'b1;
    wt(6);
    chk("oe before delay", 1, output_enable);
    wt(10);
    chk("oe after delay", 0, output_enable);
    chk("ocp lamp", 1, leds.overcurrent_trip);
    chk("armed lamp", 1, leds.ocp_armed);
    cc_mode = 1'b0;
    overcurrent_shutdown_armed = 1'b0;
    wt(3);
    chk("oe before on", 0, output_enable);
    on_pulse();
    chk("oe on", 1, output_enable);
  endtask
  // step digit cycles per display; set view times out
  task automatic t_res;
    i_fppc_op.turn(1);
    chk("right view", fppc_pkg::FPPC_VIEW_SET, right_view);
    for (int i = 1; i < 4; i++) begin
      i_fppc_op.press(8);
      chk("right res", i % 3, right_res);
      chk("left res", 0, left_res);
    end
    wt(IDLE + 4);
    chk("right view idle", fppc_pkg::FPPC_VIEW_MEAS, right_view);
  endtask
  task automatic t_menu;
    i_fppc_op.press(1);
    chk("menu open", fppc_pkg::FPPC_VIEW_MENU, left_view);
    c = func_code;
    i_fppc_op.press(1);
    chk("code fwd", (c + 6'h1) & 6'h0F, func_code);
    i_fppc_op.hold(3);
    i_fppc_op.press(1);
    i_fppc_op.rel(3);
    chk("code back", c, func_code);
    commit_seen = 1'b0;
    i_fppc_op.press(3);
    chk("pending", 1, pend_blink);
    i_fppc_op.press(5);
    chk("commit", 1, commit_seen);
    chk("left meas", fppc_pkg::FPPC_VIEW_MEAS, left_view);
    i_fppc_op.press(1);
    chk("reopen code", c, func_code);
    i_fppc_op.press(3);
    commit_seen = 1'b0;
    i_fppc_op.turn(0);
    chk("menu left", fppc_pkg::FPPC_VIEW_MEAS, left_view);
    chk("discard", 0, commit_seen | pend_blink);
    i_fppc_op.press(1);
    param_blinks = 1'b0;
    i_fppc_op.press(3);
    chk("no blink", 0, pend_blink);
    param_numeric = 1'b1;
    i_fppc_op.press(8);
    chk("menu res", 1, right_res);
    i_fppc_op.press(5);
    param_numeric = 1'b0;
    param_blinks = 1'b1;
  endtask
  // key chord lock, short hold keeps it, long hold frees it
  task automatic t_lock;
    i_fppc_op.hold(6);
    i_fppc_op.press(7);
    i_fppc_op.rel(6);
    chk("locked", 1, leds.panel_lock);
    i_fppc_op.press(4);
    chk("oe locked", 1, output_enable);
    i_fppc_op.hold(6);
    wt(HOLD / 2);
    i_fppc_op.rel(6);
    chk("short hold", 1, leds.panel_lock);
    i_fppc_op.hold(6);
    wt(HOLD);
    chk("unlocked", 0, leds.panel_lock);
    i_fppc_op.rel(6);
  endtask
  task automatic t_remote;
    i_fppc_op.press(4);
    chk("oe toggled", 0, output_enable);
    remote_cmd = 1'b1;
    wt(1);
    remote_cmd = 1'b0;
    wt(3);
    chk("remote lamp", 1, leds.remote);
    i_fppc_op.press(4);
    chk("oe remote", 0, output_enable);
    local_lockout = 1'b1;
    i_fppc_op.press(6);
    chk("lockout", 1, leds.remote);
    chk("lock lamp llo", 0, leds.panel_lock);
    local_lockout = 1'b0;
    i_fppc_op.press(6);
    chk("local", 0, leds.remote);
  endtask
  task automatic t_trig;
    trigger_panel_lock_setting = 1'b1;
    trigger_in = 1'b1;
    wt(3);
    chk("trig lock", 1, leds.panel_lock);
    i_fppc_op.hold(6);
    wt(HOLD);
    i_fppc_op.rel(6);
    chk("trig hold", 1, leds.panel_lock);
    trigger_in = 1'b0;
    i_fppc_op.hold(6);
    wt(HOLD);
    i_fppc_op.rel(6);
    chk("trig free", 0, leds.panel_lock);
    trigger_panel_lock_setting = 1'b0;
  endtask
  task automatic t_misc;
    for (int i = 0; i < 4; i++) begin
      {bus_addressed, bus_srq} = i[1:0];
      wt(2);
      chk("bus lamps", i[1:0], {leds.addressed, leds.srq});
    end
    // self-test first, then sequence mode; both must blink the ready lamp
    for (int j = 0; j < 2; j++) begin
      {self_test, sequence_run} = j ? 2'b01 : 2'b10;
      ones = 0;
      for (int i = 0; i < 16; i++) begin
        wt(1);
        ones += (leds.ready === 1'b1);
      end
      chk("ready blinks", 1, ones > 0 && ones < 16);
    end
    {self_test, sequence_run} = 2'b00;
    i_fppc_op.turn(0);
    i_fppc_op.press(8);
    rst_seen = 1'b0;
    i_fppc_op.hold(6);
    i_fppc_op.press(5);
    i_fppc_op.rel(6);
    chk("default reset", 1, rst_seen);
    chk("left res fine", 0, left_res);
  endtask
  initial begin
    rst_seen = 1'b0;
    commit_seen = 1'b0;
    wt(6);
    sys_rst = 1'b0;
    wt(3);
    chk("ready", 1, leds.ready);
    t_ovp();
    t_otp();
    t_ocp();
    t_res();
    t_menu();
    t_lock();
    t_remote();
    t_trig();
    t_misc();
    end_sim();
  end
endmodule
